//--- logic/config_logic_cell.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module config_logic_cell (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Signal sources
  input  wire logic [3:0]  ext_pin_input_i,   // Pin-routed inputs, codes 0-3
  input  wire logic [2:0]  cell_result_i,     // Results of cells one to three
  input  wire logic [20:0] periph_signals_i,  // Codes 8-27, index = code-8; bit 20 unused
  input  wire logic        fast_internal_osc_i,
  input  wire logic        slow_internal_osc_i,
  input  wire logic        converter_rc_osc_i,
  input  wire logic        sys_clk_level_i,   // Sampled system clock level
  // Results
  output logic             cell_out_o,        // Cell output, registered
  output logic             irq_o              // Interrupt request
);
  cell_cfg_if cfg ();

  // ------------------------------------------------------------
  // Configuration storage
  // ------------------------------------------------------------
  logic [7:0]  control;      // Enable, edges, mode
  logic [7:0]  polarity;     // Output and gate inversion
  logic [19:0] select_codes; // Selector codes, not reset
  logic [31:0] gate_sel;     // Gate enables, not reset
  logic        cell_irq_flag;
  logic        cell_irq_enable;
  logic        peripheral_irq_enable;
  logic        global_irq_enable;
  logic        out_prev;     // Previous cell output
  logic [31:0] in_bus;       // Assembled input bus
  logic        wr_en;        // Write strobe at access completion
  logic        rd_en;        // Read strobe in setup phase
  logic        rise_det;
  logic        fall_det;
  logic        flag_clear;
  logic [31:0] next_rdata;
  localparam logic [7:0] control_wmask  = 8'h9f; // Unimplemented and read-only bits drop
  localparam logic [7:0] polarity_wmask = 8'h8f; // Unimplemented bits drop

  // ------------------------------------------------------------
  // Input bus assembly
  // ------------------------------------------------------------
  always_comb begin
    in_bus = {11'h000, periph_signals_i};
    in_bus[31:8] = {8'h00, periph_signals_i[15:0]};
    in_bus[27:8] = periph_signals_i[19:0];
    in_bus[cell_pkg::code_sys_clk]  = sys_clk_level_i;
    in_bus[cell_pkg::code_fast_osc] = fast_internal_osc_i;
    in_bus[cell_pkg::code_slow_osc] = slow_internal_osc_i;
    in_bus[cell_pkg::code_conv_osc] = converter_rc_osc_i;
    in_bus[cell_pkg::code_reserved] = 1'b0;                 // Reserved reads zero
    in_bus[cell_pkg::code_cell_three:cell_pkg::code_cell_one] = cell_result_i;
    in_bus[3:0] = ext_pin_input_i;
  end

  // ------------------------------------------------------------
  // Bus strobes; zero wait state
  // ------------------------------------------------------------
  assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;

  // Ready high in access phase only
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
    end
  end

  // Control and polarity are cleared by reset
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      control  <= cell_pkg::control_reset;
      polarity <= 8'h00;
    end else if (wr_en && paddr_i == cell_pkg::off_control) begin
      control <= pwdata_i[7:0] & control_wmask;          // Output bit read-only
    end else if (wr_en && paddr_i == cell_pkg::off_polarity) begin
      polarity <= pwdata_i[7:0] & polarity_wmask;
    end
  end

  // Selector and gate fields hold across reset, left unset at power-up
  always_ff @(posedge core_clk_i) begin
    if (wr_en && paddr_i == cell_pkg::off_select) begin
      select_codes <= pwdata_i[19:0];
    end
    if (wr_en && paddr_i == cell_pkg::off_gates) begin
      gate_sel <= pwdata_i;
    end
  end

  // Interrupt enables
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cell_irq_enable       <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
    end else if (wr_en && paddr_i == cell_pkg::off_irq) begin
      cell_irq_enable       <= pwdata_i[cell_pkg::irq_ie_pos];
      peripheral_irq_enable <= pwdata_i[cell_pkg::irq_pe_pos];
      global_irq_enable     <= pwdata_i[cell_pkg::irq_ge_pos];
    end
  end

  // ------------------------------------------------------------
  // Configuration to core
  // ------------------------------------------------------------
  assign cfg.selector_code           = select_codes;
  assign cfg.gate_select             = gate_sel;
  assign cfg.gate_output_invert_bits = polarity[3:0];
  assign cfg.function_select_code    = control[2:0];
  assign cfg.output_invert_bit       = polarity[cell_pkg::pol_out_pos];
  assign cfg.cell_enable_bit         = control[cell_pkg::ctl_enable_pos];

  cell_core u_core (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .in_bus_i   (in_bus),
    .cfg        (cfg)
  );

  // ------------------------------------------------------------
  // Edge detection and flag
  // ------------------------------------------------------------
  // Previous output registered each cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_prev <= 1'b0;
    end else begin
      out_prev <= cfg.cell_result;
    end
  end

  // Polarity flips show up as edges too
  assign rise_det = cfg.cell_result & ~out_prev & control[cell_pkg::ctl_rise_pos];
  assign fall_det = ~cfg.cell_result & out_prev & control[cell_pkg::ctl_fall_pos];
  assign flag_clear = wr_en && paddr_i == cell_pkg::off_irq && pwdata_i[cell_pkg::irq_flag_pos];

  // Hardware never clears the flag by itself
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cell_irq_flag <= 1'b0;
    end else if (rise_det | fall_det) begin
      cell_irq_flag <= 1'b1;                            // Set beats clear
    end else if (flag_clear) begin
      cell_irq_flag <= 1'b0;
    end
  end

  // Registered interrupt request and cell output
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o      <= 1'b0;
      cell_out_o <= 1'b0;
    end else begin
      irq_o      <= cell_irq_flag & cell_irq_enable & peripheral_irq_enable
                    & global_irq_enable & control[cell_pkg::ctl_enable_pos];
      cell_out_o <= cfg.cell_result;
    end
  end

  // ------------------------------------------------------------
  // Read data, registered in setup, valid in access
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      cell_pkg::off_control: begin
        next_rdata[7:0] = control;
        next_rdata[cell_pkg::ctl_out_pos] = cfg.cell_result;
      end
      cell_pkg::off_polarity: next_rdata[7:0] = polarity;
      cell_pkg::off_select:   next_rdata[19:0] = select_codes;
      cell_pkg::off_gates:    next_rdata = gate_sel;
      cell_pkg::off_irq:      next_rdata[3:0] = {global_irq_enable, peripheral_irq_enable,
                                                 cell_irq_enable, cell_irq_flag};
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (rd_en | (psel_i & ~penable_i)) begin
      prdata_o  <= rd_en ? next_rdata : 32'h0000_0000;
      pslverr_o <= paddr_i > cell_pkg::off_irq || paddr_i[1:0] != 2'h0;
    end else if (!psel_i) begin
      pslverr_o <= 1'b0;
    end
  end
endmodule : config_logic_cell
`default_nettype wire

//--- logic/cell_pkg.sv
`default_nettype none
package cell_pkg;
  // ------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ------------------------------------------------------------
  localparam logic [7:0] off_control  = 8'h00; // Enable, edge enables, mode, output
  localparam logic [7:0] off_polarity = 8'h04; // Output and gate inversion
  localparam logic [7:0] off_select   = 8'h08; // Four 5-bit selector codes
  localparam logic [7:0] off_gates    = 8'h0c; // Four 8-bit gate enable bytes
  localparam logic [7:0] off_irq      = 8'h10; // Flag, irq enables, write 1 clears flag

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ctl_enable_pos = 7;  // Cell enable
  localparam int ctl_out_pos    = 5;  // Read-only cell output
  localparam int ctl_rise_pos   = 4;  // Rising edge irq enable
  localparam int ctl_fall_pos   = 3;  // Falling edge irq enable
  localparam int pol_out_pos    = 7;  // Output invert
  localparam int irq_flag_pos   = 0;  // Sticky flag
  localparam int irq_ie_pos     = 1;  // Cell irq enable
  localparam int irq_pe_pos     = 2;  // Peripheral irq enable
  localparam int irq_ge_pos     = 3;  // Global irq enable
  localparam int sel_width      = 5;  // Selector code width
  localparam int gate_width     = 8;  // Enables per gate
  localparam int num_lines      = 4;  // Selected lines and gates
  localparam int num_inputs     = 32; // Input bus entries

  // ------------------------------------------------------------
  // Selector codes with fixed sources
  // ------------------------------------------------------------
  localparam logic [4:0] code_sys_clk   = 5'h1f;
  localparam logic [4:0] code_fast_osc  = 5'h1e;
  localparam logic [4:0] code_slow_osc  = 5'h1d;
  localparam logic [4:0] code_conv_osc  = 5'h1c;
  localparam logic [4:0] code_reserved  = 5'h07;
  localparam logic [4:0] code_cell_one  = 5'h04;
  localparam logic [4:0] code_cell_two  = 5'h05;
  localparam logic [4:0] code_cell_three = 5'h06;

  // Reset value of control word
  localparam logic [7:0] control_reset = 8'h00;

  // Function select codes
  typedef enum logic [2:0] {
    fn_and_or, fn_or_xor, fn_and4, fn_sr_latch,
    fn_dff_sr, fn_dff2_r, fn_jk_r, fn_dlatch_sr
  } function_t;
endpackage : cell_pkg
`default_nettype wire

//--- logic/cell_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
// Configuration handed from register file to the logic core
interface cell_cfg_if;
  logic [19:0] selector_code;           // Four selector codes
  logic [31:0] gate_select;             // Four gate enable bytes
  logic [3:0]  gate_output_invert_bits; // Gate inversions
  logic [2:0]  function_select_code;    // Function
  logic        output_invert_bit;       // Output polarity
  logic        cell_enable_bit;         // Cell enable
  logic        cell_result;             // Post-polarity output
  modport regs (output selector_code, gate_select, gate_output_invert_bits,
                output function_select_code, output_invert_bit, cell_enable_bit,
                input cell_result);
  modport core (input selector_code, gate_select, gate_output_invert_bits,
                input function_select_code, output_invert_bit, cell_enable_bit,
                output cell_result);
endinterface : cell_cfg_if
`default_nettype wire

//--- logic/cell_core.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Selection, gating, function and polarity stages
// ------------------------------------------------------------
module cell_core (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic [31:0]   in_bus_i,  // Fully assembled input bus
  cell_cfg_if.core           cfg
);
  logic [3:0] sel_line;  // Selected data lines
  logic [3:0] gate_out;  // Gate outputs after gate inversion
  logic       fn_out;    // Function stage output
  logic       state_q;   // Storage for latch and flip-flop functions
  logic       next_state;
  logic       clk_prev;  // Gate 1 previous value, used as function clock

  // One selector and one gate per line
  genvar g;
  generate
    for (g = 0; g < cell_pkg::num_lines; g++) begin : g_line
      logic [7:0] en;    // Enables of this gate
      logic       prod;  // AND of the enabled terms
      logic       clash; // Some line enabled in both forms
      // 5-bit code indexes the input bus
      assign sel_line[g] =
        in_bus_i[cfg.selector_code[g*cell_pkg::sel_width +: cell_pkg::sel_width]];
      assign en = cfg.gate_select[g*cell_pkg::gate_width +: cell_pkg::gate_width];
      // Even bits enable true, odd bits inverted form of each line; empty AND is 1,
      // so inverting gives 0, which is the no-input constant
      assign prod = (~en[0] | sel_line[0]) & (~en[1] | ~sel_line[0])
                  & (~en[2] | sel_line[1]) & (~en[3] | ~sel_line[1])
                  & (~en[4] | sel_line[2]) & (~en[5] | ~sel_line[2])
                  & (~en[6] | sel_line[3]) & (~en[7] | ~sel_line[3]);
      assign clash = (en[0] & en[1]) | (en[2] & en[3]) | (en[4] & en[5]) | (en[6] & en[7]);
      // Polarity 0 yields NAND/OR/logic 0; a clash forces zero whatever the polarity
      assign gate_out[g] = ~clash
                         & ~(prod ^ cfg.gate_output_invert_bits[g]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Function stage, clock edges sampled on the core clock
  // ------------------------------------------------------------
  logic clk_rise;
  assign clk_rise = gate_out[0] & ~clk_prev;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= gate_out[0];
    end
  end

  // Next state for storage functions
  always_comb begin
    next_state = state_q;
    case (cell_pkg::function_t'(cfg.function_select_code))
      cell_pkg::fn_sr_latch: begin
        if (gate_out[2] | gate_out[3]) next_state = 1'b0;       // Reset dominates
        else if (gate_out[0] | gate_out[1]) next_state = 1'b1;
      end
      cell_pkg::fn_dff_sr: begin
        if (gate_out[2]) next_state = 1'b0;
        else if (gate_out[3]) next_state = 1'b1;
        else if (clk_rise) next_state = gate_out[1];
      end
      cell_pkg::fn_dff2_r: begin
        if (gate_out[2]) next_state = 1'b0;
        else if (clk_rise) next_state = gate_out[1] & gate_out[3];
      end
      cell_pkg::fn_jk_r: begin
        if (gate_out[2]) next_state = 1'b0;
        else if (clk_rise) begin
          case ({gate_out[1], gate_out[3]})
            2'b10:   next_state = 1'b1;
            2'b01:   next_state = 1'b0;
            2'b11:   next_state = ~state_q;
            default: next_state = state_q;
          endcase
        end
      end
      cell_pkg::fn_dlatch_sr: begin
        if (gate_out[2]) next_state = 1'b0;
        else if (gate_out[3]) next_state = 1'b1;
        else if (gate_out[0]) next_state = gate_out[1];  // Transparent while gate 1 high
      end
      default: next_state = state_q;
    endcase
  end

  // Storage cleared while disabled so re-enable starts from zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= 1'b0;
    end else if (!cfg.cell_enable_bit) begin
      state_q <= 1'b0;
    end else begin
      state_q <= next_state;
    end
  end

  // Combinational functions bypass storage
  always_comb begin
    case (cell_pkg::function_t'(cfg.function_select_code))
      cell_pkg::fn_and_or: fn_out = (gate_out[0] & gate_out[1]) | (gate_out[2] & gate_out[3]);
      cell_pkg::fn_or_xor: fn_out = (gate_out[0] | gate_out[1]) ^ (gate_out[2] | gate_out[3]);
      cell_pkg::fn_and4:   fn_out = &gate_out;
      default:             fn_out = state_q;
    endcase
  end

  // Polarity stage; disabled cell outputs zero
  assign cfg.cell_result = cfg.cell_enable_bit & (fn_out ^ cfg.output_invert_bit);
endmodule : cell_core
`default_nettype wire

//--- tb/config_logic_cell_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Port-level checks for the logic cell
// ------------------------------------------------------------
module config_logic_cell_properties (
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        cell_out_o,
  input wire logic        irq_o
);
  default clocking dflt @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic       setup;     // Setup phase of a transfer
  logic       bad_addr;  // Outside the map or misaligned
  logic       wr_done;   // Write completing this cycle
  logic [1:0] wr_hist;   // Writes of the last two cycles
  logic       en_shadow; // Enable bit as software last wrote it
  logic [1:0] en_hist;   // Older enable values
  logic [2:0] out_q;     // Recent output samples
  logic       cause;     // Output moved or software wrote lately

  assign setup    = psel_i && !penable_i;
  assign bad_addr = (paddr_i > 8'h10) || (paddr_i[1:0] != 2'h0);
  assign wr_done  = psel_i && penable_i && pwrite_i && pready_o;
  assign cause    = (out_q != {3{cell_out_o}}) || wr_done || (wr_hist != 2'h0);

  // History kept so irq and output rules can look back a few cycles
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_hist   <= 2'h0;
      en_shadow <= 1'b0;
      en_hist   <= 2'h0;
      out_q     <= 3'h0;
    end else begin
      wr_hist <= {wr_hist[0], wr_done};
      en_hist <= {en_hist[0], en_shadow};
      out_q   <= {out_q[1:0], cell_out_o};
      if (wr_done && paddr_i == cell_pkg::off_control) begin
        en_shadow <= pwdata_i[cell_pkg::ctl_enable_pos];
      end
    end
  end

  chk_ready_zero: assert property (setup |=> pready_o)
    else $error("ready missing in access phase");
  chk_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  chk_err_bad_addr: assert property (setup && bad_addr |=> pslverr_o)
    else $error("unmapped access not refused");
  chk_err_good_addr: assert property (setup && !bad_addr |=> !pslverr_o)
    else $error("mapped access refused");
  chk_bad_read_zero: assert property (setup && bad_addr && !pwrite_i |=> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_off_holds_zero: assert property (!en_shadow && en_hist == 2'h0 |-> !cell_out_o)
    else $error("disabled cell output not zero");
  chk_irq_has_cause: assert property ($rose(irq_o) |-> cause)
    else $error("irq rose without edge or write");
  chk_irq_sticky: assert property (irq_o && !wr_done && wr_hist == 2'h0 |=> irq_o)
    else $error("irq cleared without software");
  chk_reset_quiet: assert property ($fell(reset_i) |-> !irq_o && !cell_out_o && !pready_o)
    else $error("outputs active at reset release");
endmodule : config_logic_cell_properties

bind config_logic_cell config_logic_cell_properties chk_u (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .cell_out_o(cell_out_o), .irq_o(irq_o)
);
`default_nettype wire

//--- tb/tb_config_logic_cell.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module tb_config_logic_cell;
  logic        clk, rst, psel, penable, pwrite;  // Clock, reset, APB control
  logic [7:0]  paddr;                            // APB address
  logic [31:0] pwdata, prdata;                   // APB data
  logic        pready, pslverr, cell_out, irq;   // Design answers
  logic [3:0]  ext_pins;                         // Pin inputs, codes 0-3
  logic [2:0]  cell_res;                         // Other cells, codes 4-6
  logic [20:0] periph;                           // Peripheral events
  logic        fast_osc, slow_osc, conv_osc, sys_lvl; // Clock sources
  int          fail_count, checked;              // Report counters

  config_logic_cell dut_u (.core_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ext_pin_input_i(ext_pins), .cell_result_i(cell_res), .periph_signals_i(periph),
    .fast_internal_osc_i(fast_osc), .slow_internal_osc_i(slow_osc),
    .converter_rc_osc_i(conv_osc), .sys_clk_level_i(sys_lvl),
    .cell_out_o(cell_out), .irq_o(irq));

  // 100 MHz clock
  always #5 clk = ~clk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task conclude;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // One APB transfer; waits on ready with a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin fail_count++; conclude(); end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q; logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask : rd_chk
  // Spreads a 32-entry source image over the input ports
  task drive_bus(input logic [31:0] b);
    @(posedge clk);
    ext_pins <= b[3:0]; cell_res <= b[6:4]; periph <= {1'b0, b[27:8]};
    conv_osc <= b[28]; slow_osc <= b[29]; fast_osc <= b[30]; sys_lvl <= b[31];
  endtask : drive_bus
  // Output settles one registered stage after the result
  task chk_out(input logic x);
    repeat (3) @(posedge clk);
    `CHK(cell_out, x)
  endtask : chk_out
  task wait_irq(input logic x);
    int n;
    n = 0;
    while (irq !== x && n < 10) begin @(posedge clk); n++; end
    `CHK(irq, x)
    if (irq !== x) conclude();
  endtask : wait_irq
  // Disable, configure, enable last: gate 1 ANDs one code on all lines
  task cfg_follow(input int c, input logic inv, input logic [31:0] ctl);
    wr(cell_pkg::off_control, 32'h0);
    wr(cell_pkg::off_select, 32'(c) * 32'h8421);
    wr(cell_pkg::off_gates, 32'h55);
    wr(cell_pkg::off_polarity, {24'h0, inv, 7'h0f});
    wr(cell_pkg::off_control, ctl);
  endtask : cfg_follow

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    logic [31:0] q; logic e;
    rd_chk(cell_pkg::off_control, 32'h0);
    rd_chk(cell_pkg::off_irq, 32'h0);
    wr(cell_pkg::off_control, 32'h7f);
    rd_chk(cell_pkg::off_control, 32'h1f);
    apb(1'b0, 8'h14, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0})
    apb(1'b0, 8'h02, 32'h0, q, e);
    `CHK(e, 1'b1)
    $display("test regs done");
  endtask : t_regs

  task t_select;
    cfg_follow(0, 1'b0, 32'h82);
    for (int c = 0; c < 32; c++) begin
      wr(cell_pkg::off_select, 32'(c) * 32'h8421);
      for (int v = 0; v < 2; v++) begin
        drive_bus(v ? (32'h1 << c) : ~(32'h1 << c));
        chk_out((c == 7) ? 1'b0 : v[0]);
      end
    end
    $display("test select done");
  endtask : t_select

  function automatic logic gexp(logic [7:0] g, logic p, logic [3:0] l);
    case (g)
      8'h55:   return p ? &l : ~&l;
      8'haa:   return p ? ~|l : |l;
      8'h00:   return p;
      default: return 1'b0;
    endcase
  endfunction : gexp

  task t_gates;
    logic [7:0] gs [7];
    logic [6:0] gp;
    gs = '{8'h55, 8'h55, 8'haa, 8'haa, 8'h00, 8'h00, 8'h03};
    gp = 7'b0100101;
    wr(cell_pkg::off_select, 32'h18820);
    for (int i = 0; i < 7; i++) begin
      wr(cell_pkg::off_gates, {24'h0, gs[i]});
      wr(cell_pkg::off_polarity, {28'h0, 3'h7, gp[i]});
      for (int p = 0; p < 16; p++) begin
        drive_bus(32'(p));
        chk_out(gexp(gs[i], gp[i], p[3:0]));
      end
    end
    $display("test gates done");
  endtask : t_gates

  task t_funcs;
    logic [3:0] sr [4];
    logic [3:0] g;
    logic [7:0] st [21];  // Expected, mode, gate levels
    sr = '{4'h1, 4'h0, 4'h4, 4'h0};
    wr(cell_pkg::off_gates, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(cell_pkg::off_control, 32'h80 | m);
      for (int p = 0; p < 16; p++) begin
        g = p[3:0];
        wr(cell_pkg::off_polarity, 32'(p));
        chk_out(m == 0 ? (g[0] & g[1]) | (g[2] & g[3]) :
                m == 1 ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g);
      end
    end
    wr(cell_pkg::off_control, 32'h83);
    for (int s = 0; s < 4; s++) begin
      wr(cell_pkg::off_polarity, {28'h0, sr[s]});
      chk_out(s < 2);
    end
    st = '{8'h42, 8'hc3, 8'hc1, 8'hc0, 8'h41, 8'hc8, 8'h44, 8'h50, 8'h5a, 8'hdb, 8'hd1,
           8'hd0, 8'h53, 8'h60, 8'he3, 8'hea, 8'h6b, 8'hf3, 8'hf2, 8'h71, 8'hf8};
    // Clocked and latched functions; gate 1 is the clock or latch enable
    for (int i = 0; i < 21; i++) begin
      wr(cell_pkg::off_control, {24'h0, 5'h10, st[i][6:4]});
      wr(cell_pkg::off_polarity, {28'h0, st[i][3:0]});
      chk_out(st[i][7]);
    end
    $display("test functions done");
  endtask : t_funcs

  task t_irq;
    cfg_follow(0, 1'b0, 32'h92);
    drive_bus(32'h0);
    wr(cell_pkg::off_irq, 32'hf);
    drive_bus(32'h1);
    wait_irq(1'b1);
    wr(cell_pkg::off_irq, 32'hf);
    wait_irq(1'b0);
    drive_bus(32'h0);
    repeat (5) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(cell_pkg::off_polarity, 32'h8f);
    wait_irq(1'b1);
    chk_out(1'b1);
    wr(cell_pkg::off_irq, 32'h7);
    wr(cell_pkg::off_control, 32'h9a);
    wr(cell_pkg::off_polarity, 32'h0f);
    repeat (5) @(posedge clk);
    `CHK(irq, 1'b0)
    rd_chk(cell_pkg::off_irq, 32'h7);
    wr(cell_pkg::off_irq, 32'he);
    wait_irq(1'b1);
    // Pin rise is detected at the very edge at which the flag clear lands
    fork
      wr(cell_pkg::off_irq, 32'hf);
      begin repeat (2) @(posedge clk); ext_pins <= 4'h1; end
    join
    rd_chk(cell_pkg::off_irq, 32'hf);
    chk_out(1'b1);
    wr(cell_pkg::off_control, 32'h1a);
    chk_out(1'b0);
    rd_chk(cell_pkg::off_control, 32'h1a);
    $display("test irq done");
  endtask : t_irq

  task t_reset;
    wr(cell_pkg::off_select, 32'h5);
    wr(cell_pkg::off_gates, 32'h12345678);
    wr(cell_pkg::off_control, 32'h85);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(cell_pkg::off_control, 32'h0);
    rd_chk(cell_pkg::off_select, 32'h5);
    rd_chk(cell_pkg::off_gates, 32'h12345678);
    $display("test reset done");
  endtask : t_reset

  // Main sequence
  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; ext_pins = 4'h0; cell_res = 3'h0; periph = 21'h0;
    fast_osc = 1'b0; slow_osc = 1'b0; conv_osc = 1'b0; sys_lvl = 1'b0;
    fail_count = 0; checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_select();
    t_gates();
    t_funcs();
    t_irq();
    t_reset();
    conclude();
  end
endmodule : tb_config_logic_cell
`default_nettype wire
